// ===== verilog/clps_regs.svh
`ifndef CLPS_REGS_SVH
`define CLPS_REGS_SVH
`define CLPS_ADDR_SAFETY    8'h06
`define CLPS_ADDR_BGCHG     8'h07
`define CLPS_ADDR_STATUS    8'h10
`define CLPS_RST_SAFETY     8'h40
`define CLPS_RST_BGCHG      8'h01
`define CLPS_CLK_HZ         250000000
`define CLPS_LOAD_SHORT_MS  4
`define CLPS_LOAD_MID_MS    131
`define CLPS_LOAD_LONG_MS   135
`define CLPS_THERM_CAP_CODE 4'h0
`endif

// ===== verilog/clps_pkg.sv
package clps_pkg;
  typedef struct packed {
    logic [3:0] charge_current_cap;
    logic [3:0] regulation_voltage_cap;
  } clps_safety_t;
  typedef struct packed {
    logic [1:0] absent_detect_policy;
    logic [1:0] supply_load_select;
    logic       background_charge_enable;
    logic [2:0] background_term_current;
  } clps_bgchg_t;
  typedef struct packed {
    logic termination_comparator;
    logic battery_below_supply_flag;
    logic linear_precharge_flag;
    logic over_temp_flag;
    logic charge_loop_active_n;
    logic input_loop_active_n;
    logic supply_valid_flag;
    logic const_voltage_flag;
  } clps_status_t;
  typedef enum logic [1:0] {
    CLPS_IDLE = 2'b00,
    CLPS_LOAD = 2'b01
  } clps_load_st_t;
endpackage

// ===== verilog/clps_sync.sv
`timescale 1ns/10ps
`default_nettype none
module clps_sync #(
  parameter int W = 8
) (
  input  wire logic         CLK_SYS_I,  // System clock
  input  wire logic         ARST_N_I,   // Async reset
  input  wire logic [W-1:0] d_i,        // Async input
  output var  logic [W-1:0] q_o         // Synchronised
);
  logic [W-1:0] s1_q;
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s1_q <= '0;
      q_o  <= '0;
    end else begin
      s1_q <= d_i;
      q_o  <= s1_q;
    end
  end
endmodule // clps_sync
`default_nettype wire

// ===== verilog/clps_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "clps_regs.svh"
module clps_top
  import clps_pkg::*;
#(
  parameter int CLK_HZ = `CLPS_CLK_HZ,
  parameter int MS_CYC = CLK_HZ / 1000,
  parameter int PERIOD_MS = 1000
) (
  input  wire logic       CLK_SYS_I,      // 250 MHz clock
  input  wire logic       ARST_N_I,       // Async reset, low
  input  wire logic [7:0] ADDR_I,         // Register address
  input  wire logic       WR_I,           // Write strobe
  input  wire logic [7:0] WDATA_I,        // Write data
  input  wire logic       RD_I,           // Read strobe
  output var  logic [7:0] RDATA_O,        // Read data, registered
  input  wire logic [7:0] STATUS_RAW_I,   // Analog status, async
  input  wire logic       CHARGE_DONE_I,  // Charge done state
  input  wire logic       THERM_OOR_I,    // Thermistor out of range
  input  wire logic [3:0] CUR_SET_I,      // Programmed current
  input  wire logic [3:0] VOLT_SET_I,     // Programmed voltage
  output var  logic [3:0] CUR_USE_O,      // Clamped current
  output var  logic [3:0] VOLT_USE_O,     // Clamped voltage
  output var  logic       ABSENT_DET_EN_O,// Do absent detection
  output var  logic       SUPPLY_LOAD_O,  // Load supply now
  output var  logic       BG_EN_O,        // Background charge on
  output var  logic [2:0] BG_TERM_O       // Background term current
);
  localparam int LOAD0 = `CLPS_LOAD_SHORT_MS;
  localparam int LOAD1 = `CLPS_LOAD_MID_MS;
  localparam int LOAD2 = `CLPS_LOAD_LONG_MS;

  typedef struct packed {
    clps_safety_t  safety;
    clps_bgchg_t   bg;
    logic [7:0]    rdata;
    clps_load_st_t st;
    logic [31:0]   cyc;
    logic [15:0]   ms;
    logic [3:0]    cur;
    logic [3:0]    volt;
    logic          det;
    logic          load;
  } clps_state_t;

  clps_state_t  s_q, s_d;
  clps_status_t stat;
  logic [7:0]   sync_raw;
  logic         ms_tick;
  logic [15:0]  load_ms;

  clps_sync #(.W(8)) u_sync (
    .CLK_SYS_I (CLK_SYS_I),
    .ARST_N_I  (ARST_N_I),
    .d_i       (STATUS_RAW_I),
    .q_o       (sync_raw)
  );

  assign stat    = clps_status_t'(sync_raw);
  assign ms_tick = (s_q.cyc == 32'(MS_CYC - 1));

  always_comb begin
    case (s_q.bg.supply_load_select)
      2'b01:   load_ms = 16'(LOAD0);
      2'b10:   load_ms = 16'(LOAD1);
      2'b11:   load_ms = 16'(LOAD2);
      default: load_ms = 16'h0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    // =====================================
    // Register writes and reads
    if (WR_I && ADDR_I == `CLPS_ADDR_SAFETY) begin
      s_d.safety = clps_safety_t'(WDATA_I);
    end
    if (WR_I && ADDR_I == `CLPS_ADDR_BGCHG) begin
      s_d.bg = clps_bgchg_t'(WDATA_I);
    end
    // Status address ignores writes
    if (RD_I) begin
      case (ADDR_I)
        `CLPS_ADDR_SAFETY: s_d.rdata = s_q.safety;
        `CLPS_ADDR_BGCHG:  s_d.rdata = s_q.bg;
        `CLPS_ADDR_STATUS: s_d.rdata = stat;
        default:           s_d.rdata = 8'h00;
      endcase
    end
    // =====================================
    // Clamps
    s_d.cur = (CUR_SET_I > s_q.safety.charge_current_cap) ?
              s_q.safety.charge_current_cap : CUR_SET_I;
    if (stat.over_temp_flag) begin
      s_d.cur = `CLPS_THERM_CAP_CODE;
    end
    s_d.volt = (VOLT_SET_I > s_q.safety.regulation_voltage_cap) ?
               s_q.safety.regulation_voltage_cap : VOLT_SET_I;
    // =====================================
    // Absent detection policy
    case (s_q.bg.absent_detect_policy)
      2'b11:   s_d.det = !(THERM_OOR_I && CHARGE_DONE_I);
      default: s_d.det = 1'b1;
    endcase
    // =====================================
    // Periodic supply loading
    s_d.cyc = ms_tick ? 32'h0 : s_q.cyc + 32'h1;
    if (ms_tick) begin
      s_d.ms = (s_q.ms == 16'(PERIOD_MS - 1)) ? 16'h0 : s_q.ms + 16'h1;
    end
    case (s_q.st)
      CLPS_IDLE: begin
        s_d.load = 1'b0;
        if (CHARGE_DONE_I && load_ms != 16'h0 && ms_tick && s_q.ms == 16'h0) begin
          s_d.st   = CLPS_LOAD;
          s_d.load = 1'b1;
        end
      end
      CLPS_LOAD: begin
        if (!CHARGE_DONE_I || load_ms == 16'h0 || (ms_tick && s_q.ms >= load_ms)) begin
          s_d.st   = CLPS_IDLE;
          s_d.load = 1'b0;
        end
      end
      default: begin
        s_d.st   = CLPS_IDLE;
        s_d.load = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_q        <= '0;
      s_q.safety <= clps_safety_t'(`CLPS_RST_SAFETY);
      s_q.bg     <= clps_bgchg_t'(`CLPS_RST_BGCHG);
      s_q.det    <= 1'b1;
      s_q.st     <= CLPS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA_O         = s_q.rdata;
  assign CUR_USE_O       = s_q.cur;
  assign VOLT_USE_O      = s_q.volt;
  assign ABSENT_DET_EN_O = s_q.det;
  assign SUPPLY_LOAD_O   = s_q.load;
  assign BG_EN_O         = s_q.bg.background_charge_enable;
  assign BG_TERM_O       = s_q.bg.background_term_current;
endmodule // clps_top
`default_nettype wire

// ===== bench/clps_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module clps_analog_model (
  input  wire logic        CLK_SYS_I,     // Clock
  input  wire logic [17:0] cmd_i,         // Done, oor, cur, volt, status
  output wire logic        CHARGE_DONE_I, // Charge done
  output wire logic        THERM_OOR_I,   // Thermistor out of range
  output wire logic [3:0]  CUR_SET_I,     // Current setting
  output wire logic [3:0]  VOLT_SET_I,    // Voltage setting
  output wire logic [7:0]  STATUS_RAW_I   // Loop status
);
  logic [17:0] cmd_q = 18'h0;
  // Loops move off the sampling edge
  always @(negedge CLK_SYS_I) cmd_q <= cmd_i;
  assign {CHARGE_DONE_I, THERM_OOR_I, CUR_SET_I, VOLT_SET_I, STATUS_RAW_I} = cmd_q;
endmodule // clps_analog_model
`default_nettype wire

// ===== bench/clps_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "clps_regs.svh"
module clps_checker (
  input wire logic CLK_SYS_I, ARST_N_I, WR_I, RD_I, CHARGE_DONE_I, THERM_OOR_I,
  input wire logic ABSENT_DET_EN_O, SUPPLY_LOAD_O, BG_EN_O,
  input wire logic [7:0] ADDR_I, WDATA_I, RDATA_O, STATUS_RAW_I,
  input wire logic [3:0] CUR_SET_I, VOLT_SET_I, CUR_USE_O, VOLT_USE_O,
  input wire logic [2:0] BG_TERM_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_wr06; WR_I && ADDR_I == 8'h06; endsequence
  sequence s_rd06; RD_I && ADDR_I == 8'h06; endsequence
  sequence s_wr07; WR_I && ADDR_I == 8'h07; endsequence
  safety_readback_a: assert property (s_wr06 ##2 s_rd06 |=> RDATA_O == $past(WDATA_I, 3))
    else $error("safety readback wrong");
  bg_write_a: assert property (s_wr07 |=> {BG_EN_O, BG_TERM_O} == $past(WDATA_I[3:0]))
    else $error("background fields wrong");
  cur_clamp_a: assert property (CUR_USE_O <= $past(CUR_SET_I))
    else $error("current above setting");
  volt_clamp_a: assert property (VOLT_USE_O <= $past(VOLT_SET_I))
    else $error("voltage above setting");
  hot_cap_a: assert property (STATUS_RAW_I[4] [*4] |-> CUR_USE_O == `CLPS_THERM_CAP_CODE)
    else $error("hot current not capped");
  unmapped_zero_a: assert property (RD_I && ADDR_I == 8'h20 |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  read_holds_a: assert property (!RD_I |=> $stable(RDATA_O))
    else $error("read data moved");
  detect_skip_a: assert property (!ABSENT_DET_EN_O |-> $past(CHARGE_DONE_I && THERM_OOR_I))
    else $error("detection dropped");
  load_start_a: assert property ($rose(SUPPLY_LOAD_O) |-> $past(CHARGE_DONE_I))
    else $error("load outside charge done");
endmodule // clps_checker
bind clps_top clps_checker u_chk (.*);
`default_nettype wire

// ===== bench/clps_top_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "clps_regs.svh"
module clps_top_test;
  import clps_pkg::*;
  localparam int MS = 4;
  logic CLK_SYS_I = 1'b0, ARST_N_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0;
  logic [7:0] ADDR_I = 8'h00, WDATA_I = 8'h00, RDATA_O;
  logic [17:0] cmd_i = 18'h0;
  wire logic CHARGE_DONE_I, THERM_OOR_I;
  wire logic [3:0] CUR_SET_I, VOLT_SET_I;
  wire logic [7:0] STATUS_RAW_I;
  logic [3:0] CUR_USE_O, VOLT_USE_O;
  logic ABSENT_DET_EN_O, SUPPLY_LOAD_O, BG_EN_O;
  logic [2:0] BG_TERM_O;
  int error_cnt = 0, compares = 0;
  logic [15:0] n;
  logic [15:0] lt [4] = '{16'h0, 16'(`CLPS_LOAD_SHORT_MS * MS),
                          16'(`CLPS_LOAD_MID_MS * MS), 16'(`CLPS_LOAD_LONG_MS * MS)};
  clps_top #(.MS_CYC(MS), .PERIOD_MS(200)) i_dut (.*);
  clps_analog_model i_far (.*);
  always #2 CLK_SYS_I = ~CLK_SYS_I;
  task automatic report_and_stop;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge CLK_SYS_I);
    {ADDR_I, WDATA_I, WR_I} = {a, d, 1'b1};
    @(negedge CLK_SYS_I);
    WR_I = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge CLK_SYS_I);
    {ADDR_I, RD_I} = {a, 1'b1};
    @(negedge CLK_SYS_I);
    RD_I = 1'b0;
    chk("rdata", 16'(e), 16'(RDATA_O));
  endtask
  initial begin
    #40000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(negedge CLK_SYS_I);
    ARST_N_I = 1'b1;
    rd(8'h06, 8'h40);
    rd(8'h07, 8'h01);
    chk("bg", 16'h1, 16'({BG_EN_O, BG_TERM_O}));
    cmd_i = {2'b00, 4'h9, 4'h2, 8'h47};
    wr(8'h06, 8'h35);
    rd(8'h06, 8'h35);
    chk("cur", 16'h3, 16'(CUR_USE_O));
    chk("volt", 16'h2, 16'(VOLT_USE_O));
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h47);
    rd(8'h20, 8'h00);
    cmd_i = {2'b11, 4'h9, 4'h2, 8'hb8};
    wr(8'h07, 8'hc8);
    rd(8'h07, 8'hc8);
    rd(8'h10, 8'hb8);
    chk("cur", 16'(`CLPS_THERM_CAP_CODE), 16'(CUR_USE_O));
    chk("det", 16'h0, 16'(ABSENT_DET_EN_O));
    wr(8'h07, 8'h0f);
    @(negedge CLK_SYS_I);
    chk("det", 16'h1, 16'(ABSENT_DET_EN_O));
    chk("bg", 16'hf, 16'({BG_EN_O, BG_TERM_O}));
    for (int i = 0; i < 4; i++) begin
      wr(8'h07, {2'b00, i[1:0], 4'h0});
      repeat (200 * MS) @(negedge CLK_SYS_I);
      n = 16'h0;
      // One whole period holds one load window, none when supply_load_select is 0
      repeat (200 * MS) begin
        @(negedge CLK_SYS_I);
        n = n + 16'(SUPPLY_LOAD_O);
      end
      chk("load", lt[i], n);
    end
    report_and_stop;
  end
endmodule // clps_top_test
`default_nettype wire
